// File: logic/ccc_config.v
// Configuration word decode for the clock conditioning circuit, AXI4-Lite slave
//
// Notes on behaviour
// - Reference on input one divided by input_divide_field plus one.
// - PLL core feedback divided by feedback_divide_field plus one.
// - Primary global output divided by its 5-bit field plus one.
// - Second global and core outputs divided by bits 23:19 plus one.
// - Third global and core outputs divided by bits 28:24 plus one.
// - Bits 31:29 pick the VCO phase for the primary output.
// - Bits 34:32 and 37:35 pick phases for second and third pairs.
// - Bits 39:38 steer feedback: no delay, programmable delay, external.
// - Bits 44:40 set the programmable feedback delay.
// - Bit 45 inserts the fixed system delay in feedback.
// - Bits 50:46 set the primary global output delay.
// - Bits 55:51 and 60:56 set second and third global delays.
// - Bits 65:61 and 70:66 set the two core output delays.
// - Bits 71, 72, 73 pick static routing of inputs one to three.
// - Bits 76:74 choose the oscillator range gear.
// - Bits 77, 78, 79 place inputs under dynamic control.
// - Bit 80 is read-only and enables divider resync after update.
// - Bits 81 to 83 pick RC or crystal source, mixed variant only.
`timescale 1ns/10ps
`include "ccc_defines.vh"
module ccc_config #(
  parameter MIXED_VARIANT = 1
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Divided clock enables
  output wire        input_div_tick,
  output wire        feedback_div_tick,
  output wire        primary_global_out,
  output wire        second_global_out,
  output wire        second_core_out,
  output wire        third_global_out,
  output wire        third_core_out,
  // Decoded controls
  output reg  [2:0]  primary_phase_select,
  output reg  [2:0]  second_phase_select,
  output reg  [2:0]  third_phase_select,
  output reg         fb_nodelay_sel,
  output reg         fb_progdelay_sel,
  output reg         fb_external_sel,
  output reg  [4:0]  feedback_delay_field,
  output reg         system_delay_insert,
  output reg  [4:0]  primary_global_delay,
  output reg  [4:0]  second_global_delay,
  output reg  [4:0]  third_global_delay,
  output reg  [4:0]  second_core_out_delay,
  output reg  [4:0]  third_core_out_delay,
  output reg  [2:0]  input_static_route,
  output reg  [2:0]  oscillator_range_gear,
  output reg  [2:0]  input_dynamic_route,
  output reg  [2:0]  input_osc_source,
  output reg         reconfig_update_strobe
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RESP = 3'b010;
  localparam [2:0] ST_LOAD = 3'b100;

  // Shadow holds software writes; active word drives the hardware
  reg [`CCC_WORD_W-1:0] shadow;
  reg [`CCC_WORD_W-1:0] active;
  reg [2:0]             wstate;
  reg                   aw_held;
  reg                   w_held;
  reg [11:0]            aw_addr;
  reg [31:0]            w_data;
  reg [3:0]             w_strb;
  reg                   apply_pend;
  reg                   resync;

  wire [6:0] cnt_n;
  wire [6:0] cnt_m;
  wire [4:0] cnt_a;
  wire [4:0] cnt_b;
  wire [4:0] cnt_c;
  wire       tick_a;
  wire       tick_b;
  wire       tick_c;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = dat[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[11:2] <= `CCC_OFF_DIV_M >> 2);
    end
  endfunction

  assign s_axi_awready = (wstate == ST_IDLE) && !aw_held;
  assign s_axi_wready  = (wstate == ST_IDLE) && !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_take;
  wire have_w  = w_held || w_take;
  wire [11:0] cur_awaddr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] cur_wdata  = w_held ? w_data : s_axi_wdata;
  wire [3:0]  cur_wstrb  = w_held ? w_strb : s_axi_wstrb;
  wire        do_write   = (wstate == ST_IDLE) && have_aw && have_w;

  wire [31:0] sh_w2 = {7'h0, shadow[88:64]};
  // Bit 80 of the word is read-only; keep it at its fixed value
  wire [31:0] w2_new = merge(sh_w2, cur_wdata, cur_wstrb);

  // Write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      wstate       <= ST_IDLE;
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CCC_RESP_OKAY;
      shadow       <= `CCC_WORD_RESET | ({{(`CCC_WORD_W-1){1'b0}}, `CCC_DIVIDER_RESYNC_ENABLE_VAL}
                      << `CCC_DIVIDER_RESYNC_ENABLE_BIT);
      apply_pend   <= 1'b0;
    end else begin
      apply_pend <= 1'b0;
      case (wstate)
        ST_IDLE: begin
          if (aw_take && !have_w) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
          end
          if (w_take && !have_aw) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
          end
          if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(cur_awaddr) ? `CCC_RESP_OKAY : `CCC_RESP_SLVERR;
            wstate       <= ST_RESP;
            case (cur_awaddr[11:2])
              `CCC_OFF_W0 >> 2: shadow[31:0]  <= merge(shadow[31:0], cur_wdata, cur_wstrb);
              `CCC_OFF_W1 >> 2: shadow[63:32] <= merge(shadow[63:32], cur_wdata, cur_wstrb);
              `CCC_OFF_W2 >> 2: begin
                shadow[79:64] <= w2_new[15:0];
                shadow[88:81] <= (MIXED_VARIANT != 0) ? w2_new[24:17] : 8'h00;
              end
              `CCC_OFF_CTRL >> 2: apply_pend <= cur_wdata[0];
              default: begin
              end
            endcase
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wstate       <= ST_IDLE;
          end
        end
        default: wstate <= ST_IDLE;
      endcase
    end
  end

  // Whole-word transfer on the update command only
  always @(posedge aclk) begin
    if (!aresetn) begin
      active                 <= `CCC_WORD_RESET;
      reconfig_update_strobe <= 1'b0;
      resync                 <= 1'b0;
    end else begin
      reconfig_update_strobe <= apply_pend;
      resync                 <= 1'b0;
      if (apply_pend) begin
        active <= shadow;
        resync <= shadow[`CCC_DIVIDER_RESYNC_ENABLE_BIT];
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `CCC_RESP_OKAY : `CCC_RESP_SLVERR;
      case (s_axi_araddr[11:2])
        `CCC_OFF_W0 >> 2:    s_axi_rdata <= shadow[31:0];
        `CCC_OFF_W1 >> 2:    s_axi_rdata <= shadow[63:32];
        `CCC_OFF_W2 >> 2:    s_axi_rdata <= sh_w2;
        `CCC_OFF_STAT >> 2:  s_axi_rdata <= {31'h0, shadow != active};
        `CCC_OFF_DIV_A >> 2: s_axi_rdata <= {27'h0, cnt_a};
        `CCC_OFF_DIV_B >> 2: s_axi_rdata <= {27'h0, cnt_b};
        `CCC_OFF_DIV_C >> 2: s_axi_rdata <= {27'h0, cnt_c};
        `CCC_OFF_DIV_N >> 2: s_axi_rdata <= {25'h0, cnt_n};
        `CCC_OFF_DIV_M >> 2: s_axi_rdata <= {25'h0, cnt_m};
        default:             s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Decode of the active word into registered controls
  always @(posedge aclk) begin
    if (!aresetn) begin
      primary_phase_select  <= 3'h0;
      second_phase_select   <= 3'h0;
      third_phase_select    <= 3'h0;
      fb_nodelay_sel        <= 1'b1;
      fb_progdelay_sel      <= 1'b0;
      fb_external_sel       <= 1'b0;
      feedback_delay_field  <= 5'h00;
      system_delay_insert   <= 1'b0;
      primary_global_delay  <= 5'h00;
      second_global_delay   <= 5'h00;
      third_global_delay    <= 5'h00;
      second_core_out_delay <= 5'h00;
      third_core_out_delay  <= 5'h00;
      input_static_route    <= 3'h0;
      oscillator_range_gear <= 3'h0;
      input_dynamic_route   <= 3'h0;
      input_osc_source      <= 3'h0;
    end else begin
      primary_phase_select  <= active[`CCC_PRIMARY_PHASE_SELECT_LSB +: 3];
      second_phase_select   <= active[`CCC_SECOND_PHASE_SELECT_LSB +: 3];
      third_phase_select    <= active[`CCC_THIRD_PHASE_SELECT_LSB +: 3];
      // Unused code 3 falls back to no delay so feedback is never left open
      fb_progdelay_sel <= active[`CCC_FEEDBACK_PATH_SELECT_LSB +: 2] == `CCC_FB_PROGDLY;
      fb_external_sel  <= active[`CCC_FEEDBACK_PATH_SELECT_LSB +: 2] == `CCC_FB_EXTERNAL;
      fb_nodelay_sel   <= active[`CCC_FEEDBACK_PATH_SELECT_LSB +: 2] != `CCC_FB_PROGDLY &&
                          active[`CCC_FEEDBACK_PATH_SELECT_LSB +: 2] != `CCC_FB_EXTERNAL;
      feedback_delay_field  <= active[`CCC_FEEDBACK_DELAY_FIELD_LSB +: 5];
      system_delay_insert   <= active[`CCC_XDLY_BIT];
      primary_global_delay  <= active[`CCC_DLYGA_LSB +: 5];
      second_global_delay   <= active[`CCC_DLYGB_LSB +: 5];
      third_global_delay    <= active[`CCC_DLYGC_LSB +: 5];
      second_core_out_delay <= active[`CCC_DLYYB_LSB +: 5];
      third_core_out_delay  <= active[`CCC_DLYYC_LSB +: 5];
      input_static_route    <= {active[`CCC_STATC_BIT], active[`CCC_STATB_BIT],
                                active[`CCC_STATA_BIT]};
      oscillator_range_gear <= active[`CCC_VCO_LSB +: 3];
      input_dynamic_route   <= {active[`CCC_DYNC_BIT], active[`CCC_DYNB_BIT],
                                active[`CCC_DYNA_BIT]};
      input_osc_source      <= {active[`CCC_RXC_BIT], active[`CCC_RXB_BIT],
                                active[`CCC_RXA_BIT]};
    end
  end

  // Dividers; resync restarts all of them together after an update
  ccc_divider #(.W(7)) u_div_n (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .divide_field (active[`CCC_FIN_LSB +: 7]),
    .resync       (resync),
    .tick         (input_div_tick),
    .count        (cnt_n)
  );

  ccc_divider #(.W(7)) u_div_m (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .divide_field (active[`CCC_FB_LSB +: 7]),
    .resync       (resync),
    .tick         (feedback_div_tick),
    .count        (cnt_m)
  );

  ccc_divider #(.W(5)) u_div_a (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .divide_field (active[`CCC_PRIMARY_OUT_DIVIDE_FIELD_LSB +: 5]),
    .resync       (resync),
    .tick         (tick_a),
    .count        (cnt_a)
  );

  ccc_divider #(.W(5)) u_div_b (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .divide_field (active[`CCC_SECOND_OUT_DIVIDE_FIELD_LSB +: 5]),
    .resync       (resync),
    .tick         (tick_b),
    .count        (cnt_b)
  );

  ccc_divider #(.W(5)) u_div_c (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .divide_field (active[`CCC_THIRD_OUT_DIVIDE_FIELD_LSB +: 5]),
    .resync       (resync),
    .tick         (tick_c),
    .count        (cnt_c)
  );

  assign primary_global_out = tick_a;
  // Global and core outputs of a pair share one divider
  assign second_global_out  = tick_b;
  assign second_core_out    = tick_b;
  assign third_global_out   = tick_c;
  assign third_core_out     = tick_c;

endmodule

// File: logic/ccc_defines.vh
// Constants for the clock conditioning configuration block
`ifndef CCC_DEFINES_VH
`define CCC_DEFINES_VH

`define CCC_WORD_W        89
// Register byte offsets
`define CCC_OFF_W0        12'h000
`define CCC_OFF_W1        12'h004
`define CCC_OFF_W2        12'h008
`define CCC_OFF_CTRL      12'h00c
`define CCC_OFF_STAT      12'h010
`define CCC_OFF_DIV_A     12'h014
`define CCC_OFF_DIV_B     12'h018
`define CCC_OFF_DIV_C     12'h01c
`define CCC_OFF_DIV_N     12'h020
`define CCC_OFF_DIV_M     12'h024
// Field positions in the configuration word
`define CCC_FIN_LSB       0
`define CCC_FB_LSB        7
`define CCC_PRIMARY_OUT_DIVIDE_FIELD_LSB     14
`define CCC_SECOND_OUT_DIVIDE_FIELD_LSB     19
`define CCC_THIRD_OUT_DIVIDE_FIELD_LSB     24
`define CCC_PRIMARY_PHASE_SELECT_LSB     29
`define CCC_SECOND_PHASE_SELECT_LSB     32
`define CCC_THIRD_PHASE_SELECT_LSB     35
`define CCC_FEEDBACK_PATH_SELECT_LSB     38
`define CCC_FEEDBACK_DELAY_FIELD_LSB     40
`define CCC_XDLY_BIT      45
`define CCC_DLYGA_LSB     46
`define CCC_DLYGB_LSB     51
`define CCC_DLYGC_LSB     56
`define CCC_DLYYB_LSB     61
`define CCC_DLYYC_LSB     66
`define CCC_STATA_BIT     71
`define CCC_STATB_BIT     72
`define CCC_STATC_BIT     73
`define CCC_VCO_LSB       74
`define CCC_DYNA_BIT      77
`define CCC_DYNB_BIT      78
`define CCC_DYNC_BIT      79
`define CCC_DIVIDER_RESYNC_ENABLE_BIT   80
`define CCC_RXA_BIT       81
`define CCC_RXB_BIT       82
`define CCC_RXC_BIT       83
// Reset values
`define CCC_WORD_RESET    89'h0
`define CCC_DIVIDER_RESYNC_ENABLE_VAL   1'b1
// Feedback path selections
`define CCC_FB_NODELAY    2'h0
`define CCC_FB_PROGDLY    2'h1
`define CCC_FB_EXTERNAL   2'h2
// Bus responses
`define CCC_RESP_OKAY     2'h0
`define CCC_RESP_SLVERR   2'h2

`endif

// File: logic/ccc_divider.v
// Programmable clock-enable divider: pulses once every field+1 cycles
`timescale 1ns/10ps
module ccc_divider #(
  parameter W = 7
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Control
  input  wire [W-1:0] divide_field,
  input  wire         resync,
  // Output
  output reg          tick,
  output reg  [W-1:0] count
);

  always @(posedge aclk) begin
    if (!aresetn || resync) begin
      count <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (count >= divide_field) begin
      count <= {W{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule

// File: bench/ccc_fabric_model.sv
// Fabric-side model that measures the spacing of each divided clock enable
`timescale 1ns/10ps
module ccc_fabric_model (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Enables from the input and feedback dividers and the global and core outputs
  input  wire [6:0]  ticks,
  // Last spacing seen on each enable, eight bits apiece
  output reg  [55:0] periods
);
  reg [7:0] gap [0:6];
  integer   i;
  // Eight bits hold the longest legal spacing of 128 cycles
  always @(posedge aclk) begin
    for (i = 0; i < 7; i = i + 1) begin
      if (!aresetn || ticks[i]) begin
        gap[i] <= 8'h1;
      end else begin
        gap[i] <= gap[i] + 8'h1;
      end
      if (!aresetn) begin
        periods[8*i+:8] <= 8'h0;
      end else if (ticks[i]) begin
        periods[8*i+:8] <= gap[i];
      end
    end
  end
endmodule

// File: bench/ccc_config_properties.sv
// Port-level assertions for the configuration word decode block
`timescale 1ns/10ps
`include "ccc_defines.vh"
module ccc_config_props (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Decoded outputs
  input wire        second_global_out,
  input wire        second_core_out,
  input wire        third_global_out,
  input wire        third_core_out,
  input wire        fb_nodelay_sel,
  input wire        fb_progdelay_sel,
  input wire        fb_external_sel,
  input wire [2:0]  primary_phase_select,
  input wire [4:0]  feedback_delay_field,
  input wire [2:0]  oscillator_range_gear,
  input wire [2:0]  input_osc_source,
  input wire        reconfig_update_strobe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [11:0] last_ar;
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_ar <= 12'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      last_ar <= s_axi_araddr;
    end
  end
  property p_fb_onehot;
    $onehot({fb_external_sel, fb_progdelay_sel, fb_nodelay_sel});
  endproperty
  a_fb_onehot: assert property (p_fb_onehot) else $error("feedback select not one-hot");
  property p_pair_two;
    second_global_out == second_core_out;
  endproperty
  a_pair_two: assert property (p_pair_two) else $error("second pair differs");
  property p_pair_three;
    third_global_out == third_core_out;
  endproperty
  a_pair_three: assert property (p_pair_three) else $error("third pair differs");
  property p_strobe_pulse;
    reconfig_update_strobe |=> !reconfig_update_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("update strobe too long");
  property p_hold_decode;
    !reconfig_update_strobe |=> $stable({primary_phase_select, feedback_delay_field,
      oscillator_range_gear, input_osc_source, fb_external_sel, fb_progdelay_sel});
  endproperty
  a_hold_decode: assert property (p_hold_decode) else $error("decode moved without update");
  property p_ro_bit;
    s_axi_rvalid && last_ar == `CCC_OFF_W2 |-> s_axi_rdata[16];
  endproperty
  a_ro_bit: assert property (p_ro_bit) else $error("resync enable bit read low");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken with response pending");
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read taken with data pending");
  property p_b_end;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_end: assert property (p_b_end) else $error("write response repeated");
  c_update: cover property (reconfig_update_strobe);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `CCC_RESP_SLVERR);
  c_external: cover property (fb_external_sel);
endmodule
bind ccc_config ccc_config_props i_props (.*);

// File: bench/testbench.sv
// Self-checking testbench for the configuration word decode block
`timescale 1ns/10ps
`include "ccc_defines.vh"
module testbench;
  localparam [31:0] cfg_w0 = 32'ha3110302;
  localparam [31:0] cfg_w1 = 32'ha7aab15a;
  localparam [31:0] cfg_w2 = 32'h0006dabb;
  localparam [1:0]  ok_r   = `CCC_RESP_OKAY;
  localparam [1:0]  err_r  = `CCC_RESP_SLVERR;
  reg         aclk = 1'h0, aresetn = 1'h0;
  reg  [11:0] awaddr = 12'h0, araddr = 12'h0;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  wstrb = 4'h0;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire        awready, wready, bvalid, arready, rvalid, fb_n, fb_p, fb_e, sysd, upd;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [6:0]  ticks;
  wire [2:0]  ph_a, ph_b, ph_c, st_rt, gear, dyn_rt, osc;
  wire [4:0]  fbd, dga, dgb, dgc, dyb, dyc;
  wire [55:0] periods;
  wire [54:0] dec = {ph_a, ph_b, ph_c, fb_e, fb_p, fb_n, fbd, sysd, dga, dgb, dgc, dyb, dyc,
                     st_rt, gear, dyn_rt, osc};
  integer     failures = 0, num_checks = 0, strobes = 0, i;
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (upd === 1'h1) strobes <= strobes + 1;
  ccc_config i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .input_div_tick(ticks[0]), .feedback_div_tick(ticks[1]), .primary_global_out(ticks[2]),
    .second_global_out(ticks[3]), .second_core_out(ticks[4]),
    .third_global_out(ticks[5]), .third_core_out(ticks[6]),
    .primary_phase_select(ph_a), .second_phase_select(ph_b), .third_phase_select(ph_c),
    .fb_nodelay_sel(fb_n), .fb_progdelay_sel(fb_p), .fb_external_sel(fb_e),
    .feedback_delay_field(fbd), .system_delay_insert(sysd), .primary_global_delay(dga),
    .second_global_delay(dgb), .third_global_delay(dgc), .second_core_out_delay(dyb),
    .third_core_out_delay(dyc), .input_static_route(st_rt), .oscillator_range_gear(gear),
    .input_dynamic_route(dyn_rt), .input_osc_source(osc), .reconfig_update_strobe(upd)
  );
  ccc_fabric_model i_fabric (.aclk(aclk), .aresetn(aresetn), .ticks(ticks), .periods(periods));
  task chk(input string nm, input [63:0] e, input [63:0] v);
    begin
      num_checks = num_checks + 1;
      if (v !== e) begin
        failures = failures + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, v);
      end
    end
  endtask
  // Ready is sampled mid-cycle, so the handshake edge is known without racing the slave
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg       ta, tw, tb;
    reg [1:0] r;
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      tb = 1'h0;
      // Only the watchdog ends a wait that never gets an answer
      while (!tb) begin
        @(negedge aclk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        tb = bvalid;
        r = bresp;
        @(posedge aclk);
        if (ta) awvalid <= 1'h0;
        if (tw) wvalid <= 1'h0;
      end
      chk("bresp", er, tb ? r : 2'h3);
    end
  endtask
  task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    reg        ta, tr;
    reg [31:0] d;
    reg [1:0]  r;
    begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      tr = 1'h0;
      while (!tr) begin
        @(negedge aclk);
        ta = arvalid && arready;
        tr = rvalid;
        d = rdata;
        r = rresp;
        @(posedge aclk);
        if (ta) arvalid <= 1'h0;
      end
      chk("rdata", ed, d);
      chk("rresp", er, tr ? r : 2'h3);
    end
  endtask
  task apply;
    integer s0;
    begin
      s0 = strobes;
      wr(`CCC_OFF_CTRL, 32'h1, 4'hf, ok_r);
      repeat (4) @(posedge aclk);
      chk("strobes", s0 + 1, strobes);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`CCC_OFF_W0, 32'h0, ok_r);
    rd(`CCC_OFF_W2, 32'h10000, ok_r);
    // All fields are zero after reset, so every divider counter stays at zero
    for (i = 5; i < 10; i = i + 1) begin
      rd({i[9:0], 2'h0}, 32'h0, ok_r);
    end
    chk("decode", {12'h1, 43'h0}, dec);
    $display("reset test done");
    wr(`CCC_OFF_W0, cfg_w0, 4'hf, ok_r);
    wr(`CCC_OFF_W1, cfg_w1, 4'hf, ok_r);
    wr(`CCC_OFF_W2, cfg_w2, 4'hf, ok_r);
    chk("decode", {12'h1, 43'h0}, dec);
    rd(`CCC_OFF_STAT, 32'h1, ok_r);
    rd(`CCC_OFF_W2, cfg_w2 | 32'h10000, ok_r);
    apply;
    chk("decode", {9'h153, 3'h2, 5'h11, 1'h1, 5'h0a, 5'h15, 5'h07, 5'h1d, 5'h0e, 3'h5, 3'h6,
                   3'h6, 3'h3}, dec); // to
    rd(`CCC_OFF_STAT, 32'h0, ok_r);
    repeat (40) @(posedge aclk);
    chk("periods", 56'h04040303050703, periods);
    $display("load test done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(`CCC_OFF_W1, (cfg_w1 & 32'hffffff3f) | (i << 6), 4'hf, ok_r);
      apply;
      chk("feedback_path_select", (i == 1) ? 3'h2 : (i == 2) ? 3'h4 : 3'h1, {fb_e, fb_p, fb_n});
    end
    $display("feedback select test done");
    wr(12'h028, 32'hffffffff, 4'hf, err_r);
    rd(12'h028, 32'h0, err_r);
    wr(`CCC_OFF_W0, 32'hffffffff, 4'h1, ok_r);
    rd(`CCC_OFF_W0, 32'ha31103ff, ok_r);
    apply;
    repeat (300) @(posedge aclk);
    chk("in_period", 8'h80, periods[7:0]);
    $display("bus and boundary test done");
    print_verdict;
  end
endmodule
